// ===== rtl/iog_top.sv
// Our own choices: the plain strobed port.
`timescale 1ns/1ps

// ------------------------------------------------------------------
// Word FIFO
// ------------------------------------------------------------------
module iog_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  // Clock and reset
  input  wire logic         clk_in,
  input  wire logic         rstn_in,
  // Fill side
  input  wire logic         in_valid_in,
  input  wire logic [W-1:0] in_data_in,
  output      logic         in_ready_out,
  // Drain side
  output      logic         out_valid_out,
  output      logic [W-1:0] out_data_out,
  input  wire logic         out_ready_in
);
  localparam int AW = $clog2(D);

  logic [W-1:0] mem_r [D];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0]   cnt_r, cnt_nxt;
  logic          push, pop;

  always_comb begin
    push    = in_valid_in && (cnt_r != (AW+1)'(D));
    pop     = out_valid_out && out_ready_in;
    wp_nxt  = push ? AW'(wp_r + 1'b1) : wp_r;
    rp_nxt  = pop ? AW'(rp_r + 1'b1) : rp_r;
    cnt_nxt = cnt_r;
    if (push && !pop) begin
      cnt_nxt = (AW+1)'(cnt_r + 1'b1);
    end else if (pop && !push) begin
      cnt_nxt = (AW+1)'(cnt_r - 1'b1);
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // Storage has no reset; a word is only read once counted in
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_r[wp_r] <= in_data_in;
    end
  end

  assign in_ready_out  = (cnt_r != (AW+1)'(D));
  assign out_valid_out = (cnt_r != '0);
  assign out_data_out  = mem_r[rp_r];
endmodule

// ------------------------------------------------------------------
// I/O cell capture and gearbox
// ------------------------------------------------------------------
module iog_top
  import iog_pkg::*;
#(
  parameter int DQ_W   = IOG_DQ_W,
  parameter int FIFO_D = IOG_FIFO_D,
  parameter int CELLS  = IOG_GROUP_MAX
) (
  // Clock and reset
  input  wire logic                  clock_in,
  input  wire logic                  rstn_in,
  // Tri-state control
  input  wire logic                  oe_ctrl_in,
  input  wire logic                  ddr_mode_in,
  output      logic                  oe_out,
  // Deserializer
  input  wire logic [1:0]            edge_clk_in,
  input  wire logic                  edge_sel_in,
  input  wire logic                  ser_first_in,
  input  wire logic                  ser_third_in,
  input  wire logic [1:0]            deser_mode_in,
  input  wire logic                  word_align_req_in,
  input  wire logic                  word_ready_in,
  output      logic [IOG_WORD_W-1:0] word_out,
  output      logic                  word_valid_out,
  output      logic                  overrun_out,
  // Strobe and read data
  input  wire logic                  dqs_in,
  input  wire logic [DQ_W-1:0]       dq_in,
  input  wire logic [IOG_CAL_W-1:0]  cal_code_in,
  output      logic                  read_strobe_clk_out,
  output      logic                  write_strobe_clk_out,
  output      logic                  capture_polarity_sel_out,
  output      logic                  read_data_valid_out,
  output      logic [DQ_W-1:0]       rd_data_out
);

  // ----------------------------------------------------------------
  // Reset release and pin synchronizers
  // ----------------------------------------------------------------
  logic [1:0]      rst_sync_r;
  logic            rstn;
  logic [1:0]      eclk_s1_r, eclk_s2_r;
  logic [1:0]      ser_s1_r, ser_s2_r;
  logic            dqs_s1_r, dqs_s2_r;
  logic [DQ_W-1:0] dq_s1_r, dq_s2_r;

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rstn = rst_sync_r[1];

  always_ff @(posedge clock_in or negedge rstn) begin
    if (!rstn) begin
      eclk_s1_r <= '0;
      eclk_s2_r <= '0;
      ser_s1_r  <= '0;
      ser_s2_r  <= '0;
      dqs_s1_r  <= 1'b1;
      dqs_s2_r  <= 1'b1;
      dq_s1_r   <= '0;
      dq_s2_r   <= '0;
    end else begin
      eclk_s1_r <= edge_clk_in;
      eclk_s2_r <= eclk_s1_r;
      ser_s1_r  <= {ser_third_in, ser_first_in};
      ser_s2_r  <= ser_s1_r;
      dqs_s1_r  <= dqs_in;
      dqs_s2_r  <= dqs_s1_r;
      dq_s1_r   <= dq_in;
      dq_s2_r   <= dq_s1_r;
    end
  end

  // ----------------------------------------------------------------
  // Deserializer bit capture
  // ----------------------------------------------------------------
  iog_mode_e       mode;
  logic            eclk_d_r, eclk_d_nxt, eclk_cur, bit_evt;
  logic [2:0]      cnt_r, cnt_nxt, last;
  logic [7:0]      sh_a_r, sh_a_nxt;
  logic [3:0]      sh_c_r, sh_c_nxt;
  logic            slip_r, slip_nxt;
  iog_word_s       push_w;
  logic            fifo_rdy, fifo_vld;
  logic [7:0]      fifo_dat;

  assign mode = iog_mode_e'(deser_mode_in);

  always_comb begin
    eclk_cur   = edge_sel_in ? eclk_s2_r[1] : eclk_s2_r[0];
    eclk_d_nxt = eclk_cur;
    bit_evt    = eclk_cur ^ eclk_d_r; // Both edges carry a bit
    case (mode)
      IOG_MODE_BY7: last = IOG_LAST_BY7;
      IOG_MODE_BY8: last = IOG_LAST_BY8;
      default:      last = IOG_LAST_BY4;
    endcase
    sh_a_nxt    = sh_a_r;
    sh_c_nxt    = sh_c_r;
    cnt_nxt     = cnt_r;
    slip_nxt    = slip_r | word_align_req_in;
    push_w      = '0;
    if (bit_evt) begin
      sh_a_nxt = {sh_a_r[6:0], ser_s2_r[0]};
      sh_c_nxt = {sh_c_r[2:0], ser_s2_r[1]};
      if (slip_r) begin
        // Bit is swallowed: boundary moves one bit later
        slip_nxt = word_align_req_in;
      end else if (cnt_r == last) begin
        cnt_nxt      = IOG_CNT_RST;
        push_w.valid = 1'b1;
        case (mode)
          IOG_MODE_BY7:
            push_w.data = {1'b0, sh_a_nxt[6:0]};
          IOG_MODE_BY8:
            push_w.data = sh_a_nxt;
          default:
            push_w.data = {sh_a_nxt[3:0], sh_c_nxt};
        endcase
      end else begin
        cnt_nxt = 3'(cnt_r + 1'b1);
      end
    end
  end

  always_ff @(posedge clock_in or negedge rstn) begin
    if (!rstn) begin
      eclk_d_r <= 1'b0;
      cnt_r    <= IOG_CNT_RST;
      sh_a_r   <= '0;
      sh_c_r   <= '0;
      slip_r   <= 1'b0;
    end else begin
      eclk_d_r <= eclk_d_nxt;
      cnt_r    <= cnt_nxt;
      sh_a_r   <= sh_a_nxt;
      sh_c_r   <= sh_c_nxt;
      slip_r   <= slip_nxt;
    end
  end

  // Serial stream cannot stall, so a full FIFO loses the word
  iog_fifo #(
    .W (IOG_WORD_W),
    .D (FIFO_D)
  ) u_fifo (
    .clk_in        (clock_in),
    .rstn_in       (rstn),
    .in_valid_in   (push_w.valid),
    .in_data_in    (push_w.data),
    .in_ready_out  (fifo_rdy),
    .out_valid_out (fifo_vld),
    .out_data_out  (fifo_dat),
    .out_ready_in  (word_ready_in)
  );

  // ----------------------------------------------------------------
  // Parallel word to core
  // ----------------------------------------------------------------
  logic [7:0] word_r, word_nxt;
  logic       wvld_r, wvld_nxt, ovr_r, ovr_nxt;

  always_comb begin
    word_nxt = word_r;
    wvld_nxt = fifo_vld && word_ready_in;
    if (fifo_vld && word_ready_in) begin
      word_nxt = fifo_dat;
    end
    ovr_nxt = ovr_r | (push_w.valid & ~fifo_rdy);
  end

  always_ff @(posedge clock_in or negedge rstn) begin
    if (!rstn) begin
      word_r <= '0;
      wvld_r <= 1'b0;
      ovr_r  <= 1'b0;
    end else begin
      word_r <= word_nxt;
      wvld_r <= wvld_nxt;
      ovr_r  <= ovr_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Strobe delay and derived strobe clocks
  // ----------------------------------------------------------------
  logic [IOG_DLY_D-1:0] dly_r, dly_nxt;
  logic                 rsc_r, rsc_nxt, wsc_r, wsc_nxt;
  logic                 rsc_d_r, wsc_d_r, ws_rise;

  always_comb begin
    dly_nxt = {dly_r[IOG_DLY_D-2:0], dqs_s2_r};
    rsc_nxt = dly_r[cal_code_in];
    wsc_nxt = ~dqs_s2_r;
    ws_rise = wsc_r & ~wsc_d_r;
  end

  always_ff @(posedge clock_in or negedge rstn) begin
    if (!rstn) begin
      dly_r   <= '1;
      rsc_r   <= 1'b1;
      wsc_r   <= 1'b0;
      rsc_d_r <= 1'b1;
      wsc_d_r <= 1'b0;
    end else begin
      dly_r   <= dly_nxt;
      rsc_r   <= rsc_nxt;
      wsc_r   <= wsc_nxt;
      rsc_d_r <= rsc_r;
      wsc_d_r <= wsc_r;
    end
  end

  // ----------------------------------------------------------------
  // Tri-state path
  // ----------------------------------------------------------------
  logic oe_reg_r, oe_ddr_r, oe_ddr_nxt, oe_out_r, oe_out_nxt;

  always_comb begin
    oe_ddr_nxt = ws_rise ? oe_reg_r : oe_ddr_r;
    oe_out_nxt = ddr_mode_in ? oe_ddr_r : oe_ctrl_in;
  end

  // SDR flop doubles as the output flop; DDR adds two stages
  always_ff @(posedge clock_in or negedge rstn) begin
    if (!rstn) begin
      oe_reg_r <= 1'b0;
      oe_ddr_r <= 1'b0;
      oe_out_r <= 1'b0;
    end else begin
      oe_reg_r <= oe_ctrl_in;
      oe_ddr_r <= oe_ddr_nxt;
      oe_out_r <= oe_out_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Read cycle: preamble, polarity and capture
  // ----------------------------------------------------------------
  iog_state_e      st_r, st_nxt;
  logic            phase_r, pol_r, pol_nxt;
  logic [5:0]      quiet_r, quiet_nxt;
  logic            rs_edge, rs_rise;
  logic [DQ_W-1:0] hold_r, hold_nxt, rd_r, rd_nxt;
  logic            held_r, held_nxt, rdv_r, rdv_nxt;

  always_comb begin
    rs_edge   = rsc_r ^ rsc_d_r;
    rs_rise   = rsc_r & ~rsc_d_r;
    st_nxt    = st_r;
    pol_nxt   = pol_r;
    quiet_nxt = rs_edge ? '0 : 6'(quiet_r + 1'b1);
    hold_nxt  = hold_r;
    held_nxt  = held_r;
    rd_nxt    = rd_r;
    rdv_nxt   = 1'b0;
    case (st_r)
      IOG_ST_IDLE: begin
        held_nxt = 1'b0;
        // Only a fall from idle opens a preamble; postamble low is not one
        if (rs_edge && !rsc_r) begin
          st_nxt = IOG_ST_PRE;
        end
      end
      IOG_ST_PRE: begin
        if (rs_rise) begin
          st_nxt  = IOG_ST_BURST;
          pol_nxt = phase_r;
          hold_nxt = dq_s2_r;
          held_nxt = 1'b1;
        end
      end
      IOG_ST_BURST: begin
        if (rs_edge) begin
          hold_nxt = dq_s2_r;
          held_nxt = 1'b1;
        end else if (quiet_r == IOG_IDLE_LAST) begin
          st_nxt = IOG_ST_IDLE;
        end
      end
      default: st_nxt = IOG_ST_IDLE;
    endcase
    // Transfer only on the chosen phase; a strobe edge in that cycle keeps the new sample held
    if (held_r && (phase_r == pol_r)) begin
      rd_nxt  = hold_r;
      rdv_nxt = 1'b1;
      if (!rs_edge) begin
        held_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge clock_in or negedge rstn) begin
    if (!rstn) begin
      st_r    <= IOG_ST_IDLE;
      phase_r <= 1'b0;
      pol_r   <= 1'b0;
      quiet_r <= '0;
      hold_r  <= '0;
      held_r  <= 1'b0;
      rd_r    <= '0;
      rdv_r   <= 1'b0;
    end else begin
      st_r    <= st_nxt;
      phase_r <= ~phase_r;
      pol_r   <= pol_nxt;
      quiet_r <= quiet_nxt;
      hold_r  <= hold_nxt;
      held_r  <= held_nxt;
      rd_r    <= rd_nxt;
      rdv_r   <= rdv_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all from flops; group sizing width
  // ----------------------------------------------------------------
  assign oe_out                   = oe_out_r;
  assign word_out                 = word_r;
  assign word_valid_out           = wvld_r;
  assign overrun_out              = ovr_r;
  assign read_strobe_clk_out      = rsc_r;
  assign write_strobe_clk_out     = wsc_r;
  assign capture_polarity_sel_out = pol_r;
  assign read_data_valid_out      = rdv_r;
  assign rd_data_out              = rd_r;

endmodule

// ===== rtl/iog_pkg.sv
package iog_pkg;

  // ----------------------------------------------------------------
  // Deserializer modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    IOG_MODE_BY7  = 2'b00,
    IOG_MODE_BY8  = 2'b01,
    IOG_MODE_BY4  = 2'b10,
    IOG_MODE_RSVD = 2'b11
  } iog_mode_e;

  // ----------------------------------------------------------------
  // Strobe read-cycle states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    IOG_ST_IDLE  = 2'b00,
    IOG_ST_PRE   = 2'b01,
    IOG_ST_BURST = 2'b10
  } iog_state_e;

  // ----------------------------------------------------------------
  // Sizes, bit positions and counts
  // ----------------------------------------------------------------
  localparam int         IOG_WORD_W     = 8;
  localparam int         IOG_FIFO_D     = 16;
  localparam int         IOG_GROUPS     = 2;
  localparam int         IOG_GROUP_MAX  = 14;
  localparam int         IOG_GROUP_MIN  = 12;
  localparam int         IOG_DQ_W       = 16;
  localparam int         IOG_CAL_W      = 6;
  localparam int         IOG_DLY_D      = 64;
  localparam logic [2:0] IOG_LAST_BY7   = 3'h6;
  localparam logic [2:0] IOG_LAST_BY8   = 3'h7;
  localparam logic [2:0] IOG_LAST_BY4   = 3'h3;
  localparam int         IOG_HI_LSB     = 4;
  localparam int         IOG_NIB_W      = 4;
  // Strobe silence that closes a burst, in ns and in clocks
  localparam int         IOG_CLK_NS     = 10;
  localparam int         IOG_IDLE_NS    = 400;
  localparam int         IOG_IDLE_CYC   = IOG_IDLE_NS / IOG_CLK_NS;
  localparam logic [5:0] IOG_IDLE_LAST  = 6'(IOG_IDLE_CYC - 1);
  localparam logic [2:0] IOG_CNT_RST    = 3'h0;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                  valid;
    logic [IOG_DQ_W-1:0]   data;
  } iog_rd_s;

  typedef struct packed {
    logic                  valid;
    logic [IOG_WORD_W-1:0] data;
  } iog_word_s;

endpackage

// ===== verif/iog_top_props.sv
`timescale 1ns/1ps
module iog_top_props
  import iog_pkg::*;
(
  // Clock and reset
  input wire logic                  clock_in,
  input wire logic                  rstn_in,
  // Tri-state
  input wire logic                  oe_ctrl_in,
  input wire logic                  ddr_mode_in,
  input wire logic                  oe_out,
  // Words
  input wire logic [1:0]            deser_mode_in,
  input wire logic [IOG_WORD_W-1:0] word_out,
  input wire logic                  word_valid_out,
  input wire logic                  overrun_out,
  // Strobe
  input wire logic                  dqs_in,
  input wire logic [IOG_CAL_W-1:0]  cal_code_in,
  input wire logic                  read_strobe_clk_out,
  input wire logic                  write_strobe_clk_out,
  input wire logic                  capture_polarity_sel_out,
  input wire logic                  read_data_valid_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rstn_in);

  // Reset release runs through two flops, so early cycles are skipped
  logic [3:0] live_r, live_nxt;
  logic [6:0] hi_r, hi_nxt;
  logic       live;
  assign live = live_r[3];
  always_comb begin
    live_nxt = live ? live_r : live_r + 4'h1;
    hi_nxt = !dqs_in ? 7'h00 : (&hi_r ? hi_r : hi_r + 7'h01);
  end
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      live_r <= 4'h0;
      hi_r <= 7'h00;
    end else begin
      live_r <= live_nxt;
      hi_r <= hi_nxt;
    end
  end

  sequence s_sdr_run;
    !ddr_mode_in [*3];
  endsequence
  sequence s_dqs_low;
    $fell(dqs_in) ##1 !dqs_in [*5];
  endsequence

  a_oe_sdr_follow: assert property (
    live ##0 s_sdr_run |-> oe_out == $past(oe_ctrl_in))
    else $error("oe_out not following enable");
  a_oe_ddr_strobe: assert property (
    live && ddr_mode_in && $past(ddr_mode_in, 5) && $changed(oe_out)
    |-> ($past(write_strobe_clk_out) && !$past(write_strobe_clk_out, 2))
     || ($past(write_strobe_clk_out, 2) && !$past(write_strobe_clk_out, 3)))
    else $error("oe_out moved without write strobe");
  a_wstrobe_low: assert property (
    s_dqs_low |-> write_strobe_clk_out)
    else $error("write strobe not inverted strobe");
  a_rstrobe_idle: assert property (
    live && hi_r > {1'b0, cal_code_in} + 7'h06 |-> read_strobe_clk_out)
    else $error("read strobe low while strobe idle");
  a_rdv_quiet: assert property (
    read_data_valid_out |-> hi_r < 7'h08)
    else $error("read valid outside burst");
  a_word_hold: assert property (
    live && $changed(word_out) |-> word_valid_out)
    else $error("word changed without valid");
  a_by7_top: assert property (
    word_valid_out && deser_mode_in == IOG_MODE_BY7 |-> !word_out[7])
    else $error("bit 7 set in 1:7 word");
  a_ovr_sticky: assert property (
    live && overrun_out |=> overrun_out)
    else $error("overrun cleared");
  a_pol_first_rise: assert property (
    live && $changed(capture_polarity_sel_out)
    |-> $past(read_strobe_clk_out) && !$past(read_strobe_clk_out, 2))
    else $error("polarity moved away from a strobe rise");
endmodule

// ===== verif/iog_mem_model.sv
`timescale 1ns/1ps
module iog_mem_model
  import iog_pkg::*;
(
  // Clock
  input  wire logic                clock_in,
  // Burst request
  input  wire logic                go_in,
  input  wire logic [4:0]          edges_in,
  input  wire logic [2:0]          gap_in,
  // Memory pins
  output      logic                dqs_out,
  output      logic [IOG_DQ_W-1:0] dq_out,
  // Bench taps
  output      logic                sent_out,
  output      logic                busy_out
);
  logic [IOG_DQ_W-1:0] pat = 16'h5a3c;
  initial begin
    dqs_out = 1'b1;
    dq_out = 16'h0000;
    sent_out = 1'b0;
    busy_out = 1'b0;
    forever begin
      @(posedge clock_in);
      dq_out <= ~dq_out;
      if (go_in) begin
        busy_out <= 1'b1;
        dqs_out <= 1'b0;
        repeat (6) @(posedge clock_in);
        for (int i = 0; i < edges_in; i++) begin
          pat = {pat[14:0], pat[15] ^ pat[13] ^ pat[12] ^ pat[10]};
          dqs_out <= ~dqs_out;
          dq_out <= pat;
          sent_out <= 1'b1;
          @(posedge clock_in);
          sent_out <= 1'b0;
          repeat (gap_in - 1) @(posedge clock_in);
        end
        // Long postamble: release rise must come after burst close
        repeat (48) begin
          @(posedge clock_in);
          dq_out <= ~dq_out;
        end
        dqs_out <= 1'b1;
        busy_out <= 1'b0;
      end
    end
  end
endmodule

// ===== verif/iog_top_tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) \
  begin \
    checks_done++; \
    if ((g) !== (e)) begin \
      bad_count++; \
      $display("wrong value %s exp %0h got %0h", nm, e, g); \
    end \
  end

module iog_top_tb
  import iog_pkg::*;
;
  logic                  clock_in = 1'b0, rstn_in = 1'b0;
  logic                  oe_ctrl = 1'b0, ddr = 1'b0, oe;
  logic                  ser_clk = 1'b0, junk_clk = 1'b0, esel = 1'b0;
  logic                  s1 = 1'b0, s3 = 1'b0, align = 1'b0, wrdy = 1'b1;
  logic                  wval, ovr, dqs, rsc, wsc, pol, rdv, sent, busy;
  logic                  go = 1'b0;
  logic [1:0]            eclk;
  logic [4:0]            edges = 5'h02;
  logic [2:0]            gap = 3'h3;
  logic [IOG_WORD_W-1:0] word, ew;
  logic [IOG_DQ_W-1:0]   dq, rdd, er;
  logic [IOG_CAL_W-1:0]  cal = 6'h00;
  logic [31:0]           rng = 32'h0000_85fd;
  logic [7:0]            expq[$];
  logic [15:0]           rdq[$];
  iog_mode_e             mode = IOG_MODE_BY8;
  int                    bad_count = 0, checks_done = 0, jc = 0;

  always #5 clock_in = ~clock_in;
  // Unselected edge clock runs at another rate to expose a wrong pick
  assign eclk = esel ? {ser_clk, junk_clk} : {junk_clk, ser_clk};
  always @(posedge clock_in) begin
    jc <= (jc == 4) ? 0 : jc + 1;
    if (jc == 4) junk_clk <= ~junk_clk;
  end

  iog_top u_dut (
    .clock_in(clock_in), .rstn_in(rstn_in), .oe_ctrl_in(oe_ctrl),
    .ddr_mode_in(ddr), .oe_out(oe), .edge_clk_in(eclk),
    .edge_sel_in(esel), .ser_first_in(s1), .ser_third_in(s3),
    .deser_mode_in(mode), .word_align_req_in(align),
    .word_ready_in(wrdy), .word_out(word), .word_valid_out(wval),
    .overrun_out(ovr), .dqs_in(dqs), .dq_in(dq), .cal_code_in(cal),
    .read_strobe_clk_out(rsc), .write_strobe_clk_out(wsc),
    .capture_polarity_sel_out(pol), .read_data_valid_out(rdv),
    .rd_data_out(rdd));
  iog_mem_model u_mem (
    .clock_in(clock_in), .go_in(go), .edges_in(edges), .gap_in(gap),
    .dqs_out(dqs), .dq_out(dq), .sent_out(sent), .busy_out(busy));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  function automatic logic [7:0] exp_word(input iog_mode_e m,
                                          input logic [7:0] a,
                                          input logic [7:0] b);
    if (m == IOG_MODE_BY7) return {1'b0, a[6:0]};
    if (m == IOG_MODE_BY8) return a;
    return {a[3:0], b[3:0]};
  endfunction

  always @(posedge clock_in) begin
    if (sent === 1'b1) rdq.push_back(dq);
    if (wval === 1'b1) begin
      ew = (expq.size() > 0) ? expq.pop_front() : 8'hxx;
      `CHK("word_out", ew, word)
    end
    if (rdv === 1'b1) begin
      er = (rdq.size() > 0) ? rdq.pop_front() : 16'hxxxx;
      `CHK("rd_data_out", er, rdd)
    end
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic do_reset();
    rstn_in <= 1'b0;
    ser_clk <= 1'b0;
    repeat (10) @(posedge clock_in);
    expq.delete();
    rdq.delete();
    rstn_in <= 1'b1;
    repeat (4) @(posedge clock_in);
  endtask
  task automatic send_bit(input logic a, input logic b);
    s1 <= a;
    s3 <= b;
    ser_clk <= ~ser_clk;
    repeat (8) @(posedge clock_in);
  endtask
  // Queued first: the word leaves before its last bit period ends
  task automatic send_word(input logic keep);
    int n;
    rng = xs(rng);
    n = (mode == IOG_MODE_BY7) ? 7 : (mode == IOG_MODE_BY8) ? 8 : 4;
    if (keep) expq.push_back(exp_word(mode, rng[7:0], rng[15:8]));
    for (int i = n - 1; i >= 0; i--) send_bit(rng[i], rng[8 + i]);
  endtask
  task automatic burst(input logic [4:0] n, input logic [2:0] g);
    edges <= n;
    gap <= g;
    go <= 1'b1;
    @(posedge clock_in);
    go <= 1'b0;
    @(posedge clock_in);
    for (int t = 0; busy === 1'b1; t++) begin
      if (t > 2000) begin
        bad_count++;
        finish_test();
      end
      @(posedge clock_in);
    end
    repeat (10) @(posedge clock_in);
  endtask

  initial begin
    do_reset();
    `CHK("oe_out", 1'b0, oe)
    `CHK("read_strobe_clk_out", 1'b1, rsc)
    for (int m = 0; m < 4; m++) begin
      mode <= iog_mode_e'(m);
      esel <= m[0];
      do_reset();
      for (int k = 0; k < 3; k++) begin
        if (m == 1 && k == 1) begin
          align <= 1'b1;
          @(posedge clock_in);
          align <= 1'b0;
          send_bit(1'b1, 1'b1);
        end
        send_word(1'b1);
      end
      repeat (20) @(posedge clock_in);
      `CHK("words left", 0, expq.size())
    end
    mode <= IOG_MODE_BY8;
    wrdy <= 1'b0;
    do_reset();
    repeat (16) send_word(1'b1);
    `CHK("overrun_out", 1'b0, ovr)
    send_word(1'b0);
    `CHK("overrun_out", 1'b1, ovr)
    wrdy <= 1'b1;
    repeat (40) @(posedge clock_in);
    `CHK("words left", 0, expq.size())
    for (int k = 0; k < 20; k++) begin
      rng = xs(rng);
      oe_ctrl <= rng[0];
      repeat (rng[9:8] + 1) @(posedge clock_in);
    end
    oe_ctrl <= 1'b1;
    repeat (4) @(posedge clock_in);
    `CHK("oe_out", 1'b1, oe)
    ddr <= 1'b1;
    burst(5'h04, 3'h3);
    oe_ctrl <= 1'b0;
    repeat (20) @(posedge clock_in);
    `CHK("oe_out", 1'b1, oe)
    burst(5'h04, 3'h5);
    `CHK("oe_out", 1'b0, oe)
    ddr <= 1'b0;
    for (int k = 0; k < 6; k++) begin
      rng = xs(rng);
      cal <= (rng[1:0] == 2'b11) ? 6'h02 : {4'h0, rng[1:0]};
      repeat (8) @(posedge clock_in);
      // Late strobe views need the long gap to stay inside the data
      burst({1'b0, rng[5:3], 1'b0} + 5'h02,
            (rng[6] || rng[1:0] != 2'b00) ? 3'h5 : 3'h3);
      `CHK("reads left", 0, rdq.size())
    end
    finish_test();
  end

  initial begin
    repeat (60000) @(posedge clock_in);
    bad_count++;
    finish_test();
  end
endmodule

bind iog_top iog_top_props u_props (
  .clock_in(clock_in), .rstn_in(rstn_in), .oe_ctrl_in(oe_ctrl_in),
  .ddr_mode_in(ddr_mode_in), .oe_out(oe_out),
  .deser_mode_in(deser_mode_in), .word_out(word_out),
  .word_valid_out(word_valid_out), .overrun_out(overrun_out),
  .dqs_in(dqs_in), .cal_code_in(cal_code_in),
  .read_strobe_clk_out(read_strobe_clk_out),
  .write_strobe_clk_out(write_strobe_clk_out),
  .capture_polarity_sel_out(capture_polarity_sel_out),
  .read_data_valid_out(read_data_valid_out));
